// *** hdl/cpu_supervisor_regs.svh ***
`ifndef CPU_SUPERVISOR_REGS_SVH
`define CPU_SUPERVISOR_REGS_SVH

// ----------------------------------------------------------------------
// Timing constants
// ----------------------------------------------------------------------
// Clock period in ns
`define SUP_CLK_PERIOD_NS 10
// Reset hold after supply recovery and after a press, in ms
`define SUP_HOLD_MS 250
// Hold count in cycles (least time, exact division)
`define SUP_HOLD_CYCLES ((`SUP_HOLD_MS * 1000000) / `SUP_CLK_PERIOD_NS)
// Pushbutton debounce settle time in ms
`define SUP_DEBOUNCE_MS 10
`define SUP_DEBOUNCE_CYCLES \
	((`SUP_DEBOUNCE_MS * 1000000) / `SUP_CLK_PERIOD_NS)
// Watchdog timeout in ms
`define SUP_WDOG_MS 1000
`define SUP_WDOG_CYCLES ((`SUP_WDOG_MS * 1000000) / `SUP_CLK_PERIOD_NS)
// Reset value of the power-good latch
`define SUP_PWR_GOOD_RST 1'b0

`endif

// *** hdl/cpu_supervisor_pkg.sv ***
`default_nettype none
package cpu_supervisor_pkg;
	// Reset request sources
	typedef struct packed {
		logic power;
		logic button;
		logic watchdog;
	} reset_req_t;
	// Debounce/stretch phases of the pushbutton path
	typedef enum logic [1:0] {
		BTN_IDLE,
		BTN_SETTLE,
		BTN_PULSE,
		BTN_WAIT_RELEASE
	} btn_state_t;
endpackage : cpu_supervisor_pkg
`default_nettype wire

// *** hdl/hold_timer.sv ***
`default_nettype none
// Retriggerable hold: o_active stays high while i_hold is high and for
// HOLD_CYCLES cycles after it falls.
module hold_timer #(
	parameter int unsigned HOLD_CYCLES = 25000000
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_hold,
	output logic o_active
);
	localparam int W = $clog2(HOLD_CYCLES + 1);
	localparam logic [W-1:0] LOAD = W'(HOLD_CYCLES);

	typedef struct packed {
		logic [W-1:0] count;
	} hold_state_t;

	hold_state_t state;
	hold_state_t next_state;

	// Reload while held, count down afterwards
	always_comb begin
		next_state = state;
		if (i_hold) begin
			next_state.count = LOAD;
		end else if (state.count != '0) begin
			next_state.count = state.count - W'(1);
		end
	end

	// Starts loaded so the reset output is active out of reset
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			state.count <= LOAD;
		end else begin
			state <= next_state;
		end
	end

	assign o_active = i_hold || (state.count != '0);
endmodule : hold_timer
`default_nettype wire

// *** hdl/cpu_supervisor_reset_watchdog.sv ***
`include "cpu_supervisor_regs.svh"
`default_nettype none
// Contract
// RULE1 - Supply out of tolerance raises power-fail and holds reset active.
// RULE2 - After supply recovers, reset stays active a further 250 ms.
// RULE3 - Pushbutton bounce is filtered into a single press.
// RULE4 - Each accepted press yields a reset pulse of at least 250 ms.
// RULE5 - Missing strobe low before watchdog timeout forces reset; host kicks.
// RULE6 - Reset line driven low for supply, watchdog, power-up, pushbutton.
// RULE7 - External low on reset line is debounced and stretched, not passed.
// RULE8 - Reset output is the OR of power, button and watchdog requests.
module cpu_supervisor_reset_watchdog #(
	parameter int unsigned HOLD_CYCLES = `SUP_HOLD_CYCLES,
	parameter int unsigned DEBOUNCE_CYCLES = `SUP_DEBOUNCE_CYCLES,
	parameter int unsigned WDOG_CYCLES = `SUP_WDOG_CYCLES
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_supply_ok,
	input wire logic i_reset_line,
	input wire logic i_watchdog_kick_strobe_n,
	output logic o_reset_line_oe,
	output logic o_reset_line,
	output logic o_power_fail,
	output cpu_supervisor_pkg::reset_req_t o_reset_req
);
	localparam int DW = $clog2(DEBOUNCE_CYCLES + 1);
	localparam int HW = $clog2(HOLD_CYCLES + 1);
	localparam int WW = $clog2(WDOG_CYCLES + 1);
	localparam logic [DW-1:0] DB_LOAD = DW'(DEBOUNCE_CYCLES);
	localparam logic [HW-1:0] HOLD_LOAD = HW'(HOLD_CYCLES);
	localparam logic [WW-1:0] WD_LOAD = WW'(WDOG_CYCLES);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [1:0] sync_ok;
		logic [1:0] sync_line;
		logic [1:0] sync_kick;
		logic kick_prev;
		cpu_supervisor_pkg::btn_state_t btn;
		logic [DW-1:0] db_count;
		logic [HW-1:0] pulse_count;
		logic [WW-1:0] wd_count;
		logic wd_fire;
		logic drive_low;
		logic power_fail;
		cpu_supervisor_pkg::reset_req_t req;
	} sup_state_t;

	sup_state_t state;
	sup_state_t next_state;
	logic power_hold;
	logic line_low;
	logic kick_fall;
	logic any_req;

	assign line_low = ~state.sync_line[1];
	assign kick_fall = state.kick_prev & ~state.sync_kick[1];

	// ------------------------------------------------------------------
	// Power-fail hold (stretch after recovery, also covers power-up)
	// ------------------------------------------------------------------
	hold_timer #(
		.HOLD_CYCLES(HOLD_CYCLES)
	) u_power_hold (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_hold(state.power_fail),
		.o_active(power_hold)
	);

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		next_state = state;
		// Pins pass two flops before any logic reads them
		next_state.sync_ok = {state.sync_ok[0], i_supply_ok};
		next_state.sync_line = {state.sync_line[0], i_reset_line};
		next_state.sync_kick = {state.sync_kick[0], i_watchdog_kick_strobe_n};
		next_state.kick_prev = state.sync_kick[1];
		next_state.power_fail = ~state.sync_ok[1]; // RULE1

		// Button path: our own low drive reads back as a low line, so
		// presses are only looked for while we are not driving
		// Limitation: the readback stays low for two sync cycles after a
		// release, so DEBOUNCE_CYCLES must be nonzero or the echo is a press
		unique case (state.btn)
			cpu_supervisor_pkg::BTN_IDLE: begin
				if (line_low && !state.drive_low) begin // RULE7
					next_state.btn = cpu_supervisor_pkg::BTN_SETTLE;
					next_state.db_count = DB_LOAD;
				end
			end
			cpu_supervisor_pkg::BTN_SETTLE: begin
				// Any bounce high drops back to idle; press needs steady low
				if (!line_low) begin // RULE3
					next_state.btn = cpu_supervisor_pkg::BTN_IDLE;
				end else if (state.db_count == '0) begin
					next_state.btn = cpu_supervisor_pkg::BTN_PULSE;
					next_state.pulse_count = HOLD_LOAD;
				end else begin
					next_state.db_count = state.db_count - DW'(1);
				end
			end
			cpu_supervisor_pkg::BTN_PULSE: begin
				// Fixed pulse regardless of how long the button is held
				if (state.pulse_count == '0) begin // RULE4
					next_state.btn = cpu_supervisor_pkg::BTN_WAIT_RELEASE;
					next_state.db_count = DB_LOAD;
				end else begin
					next_state.pulse_count = state.pulse_count - HW'(1);
				end
			end
			cpu_supervisor_pkg::BTN_WAIT_RELEASE: begin
				// Line must read high for a settle time before re-arming,
				// so release bounce is not a second press
				if (line_low) begin // RULE3
					next_state.db_count = DB_LOAD;
				end else if (state.db_count == '0) begin
					next_state.btn = cpu_supervisor_pkg::BTN_IDLE;
				end else begin
					next_state.db_count = state.db_count - DW'(1);
				end
			end
		endcase

		// Watchdog: a falling strobe reloads; expiry gives one hold pulse.
		// Held in reload while any other reset is active.
		next_state.wd_fire = 1'b0;
		if (kick_fall || power_hold || state.req.button) begin // RULE5
			next_state.wd_count = WD_LOAD;
		end else if (state.wd_count == '0) begin
			next_state.wd_fire = 1'b1;
			next_state.wd_count = WD_LOAD;
		end else begin
			next_state.wd_count = state.wd_count - WW'(1);
		end

		next_state.req.power = power_hold; // RULE2
		next_state.req.button = (state.btn == cpu_supervisor_pkg::BTN_PULSE);
		next_state.req.watchdog = state.wd_fire;
		any_req = next_state.req.power | next_state.req.button |
			next_state.req.watchdog;
		next_state.drive_low = any_req; // RULE8

		// Watchdog expiry reuses the button stretcher for a full hold
		// pulse by entering the pulse phase, so both share one length
		if (state.wd_fire &&
				state.btn != cpu_supervisor_pkg::BTN_PULSE) begin // RULE6
			next_state.btn = cpu_supervisor_pkg::BTN_PULSE;
			next_state.pulse_count = HOLD_LOAD;
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			state <= '0;
			state.sync_ok <= {2{`SUP_PWR_GOOD_RST}};
			state.sync_line <= 2'b11;
			state.sync_kick <= 2'b11;
			state.kick_prev <= 1'b1;
			state.wd_count <= WD_LOAD;
			state.power_fail <= 1'b1;
			state.drive_low <= 1'b1;
			state.req.power <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	// Open drain: drive low only, the pullup gives the high level
	assign o_reset_line = 1'b0;
	assign o_reset_line_oe = state.drive_low; // RULE6
	assign o_power_fail = state.power_fail;
	assign o_reset_req = state.req;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	a_fail_holds_reset: assert property (@(posedge i_clk_sys) // RULE1
		disable iff (i_reset) o_power_fail |-> ##[1:2] o_reset_line_oe)
		else $error("Reset not held during power fail");
	a_or_of_sources: assert property (@(posedge i_clk_sys) // RULE8
		disable iff (i_reset)
		(|o_reset_req) == o_reset_line_oe)
		else $error("Reset output is not the OR of requests");
	a_press_pulse: assert property (@(posedge i_clk_sys) // RULE4
		disable iff (i_reset)
		$rose(o_reset_req.button) |-> o_reset_req.button [*8])
		else $error("Button reset pulse too short");
	a_pulse_load: assert property (@(posedge i_clk_sys) // RULE4
		disable iff (i_reset)
		$rose(o_reset_req.button) |->
		state.pulse_count == HOLD_LOAD - HW'(1))
		else $error("Button pulse started short");
	a_recover_hold: assert property (@(posedge i_clk_sys) // RULE2
		disable iff (i_reset)
		$fell(o_power_fail) |-> o_reset_req.power [*8])
		else $error("Reset released too soon after recovery");
	a_wdog_fires: assert property (@(posedge i_clk_sys) // RULE5
		disable iff (i_reset)
		state.wd_fire |=> o_reset_req.watchdog ##1 o_reset_req.button)
		else $error("Watchdog expiry did not reset");
	a_kick_reloads: assert property (@(posedge i_clk_sys) // RULE5
		disable iff (i_reset) kick_fall |=> state.wd_count == WD_LOAD)
		else $error("Strobe did not reload watchdog");
	a_bounce_filter: assert property (@(posedge i_clk_sys) // RULE3
		disable iff (i_reset)
		(state.btn == cpu_supervisor_pkg::BTN_SETTLE && !line_low &&
		!state.wd_fire) |=> state.btn == cpu_supervisor_pkg::BTN_IDLE)
		else $error("Bounce accepted as press");
	a_line_stretched: assert property (@(posedge i_clk_sys) // RULE7
		disable iff (i_reset)
		(state.btn == cpu_supervisor_pkg::BTN_IDLE && line_low &&
		!state.drive_low && !state.wd_fire) |=>
		(state.btn == cpu_supervisor_pkg::BTN_SETTLE &&
		!o_reset_req.button))
		else $error("Line low passed straight through");
	a_drive_only_low: assert property (@(posedge i_clk_sys) // RULE6
		disable iff (i_reset) o_reset_line_oe |-> !o_reset_line)
		else $error("Reset line driven high");
endmodule : cpu_supervisor_reset_watchdog
`default_nettype wire

// *** sim/host_button_model.sv ***
`default_nettype none
// Host processor that kicks the watchdog, plus a pushbutton on the pin
module host_button_model #(
	parameter int unsigned KICK_PERIOD = 20
) (
	input wire logic i_clk_sys,
	input wire logic i_reset_line_oe,
	input wire logic i_press,
	input wire logic i_kick_en,
	output logic o_reset_line,
	output logic o_watchdog_kick_strobe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned kick_cnt = 0;
	logic strobe_n = 1'b1;
	// Open-drain pin with pull-up: low while either party pulls it
	assign o_reset_line = !(i_reset_line_oe || i_press);
	assign o_watchdog_kick_strobe_n = strobe_n;
	// Two-cycle low kick once per period, so the sync sees a real edge
	always @(negedge i_clk_sys) begin
		kick_cnt <= (kick_cnt + 1) % KICK_PERIOD;
		strobe_n <= !(i_kick_en && kick_cnt < 2);
	end
endmodule : host_button_model
`default_nettype wire

// *** sim/tb_cpu_supervisor_reset_watchdog.sv ***
`default_nettype none
module tb_cpu_supervisor_reset_watchdog;
	timeunit 1ns;
	timeprecision 1ps;
	// Short counts keep the run brief; all expectations derive from them
	localparam int unsigned HOLD = 40;
	localparam int unsigned DEB = 4;
	localparam int unsigned WDOG = 60;
	typedef struct {int len; int bounce; int pulse;} row_t;
	row_t rows[3] = '{'{3, 0, 0}, '{20, 0, 1}, '{20, 3, 1}};
	logic i_clk_sys = 1'b0;
	logic i_reset = 1'b1;
	logic i_supply_ok = 1'b0;
	logic press = 1'b0;
	logic kick_en = 1'b1;
	wire logic reset_line;
	wire logic strobe_n;
	logic o_reset_line_oe;
	logic o_reset_line;
	logic o_power_fail;
	cpu_supervisor_pkg::reset_req_t o_reset_req;
	int mismatches = 0;
	int checks_done = 0;
	int rises;
	int highs;
	int wd_seen;
	cpu_supervisor_reset_watchdog #(.HOLD_CYCLES(HOLD),
		.DEBOUNCE_CYCLES(DEB), .WDOG_CYCLES(WDOG)) dut (
		.i_clk_sys(i_clk_sys), .i_reset(i_reset),
		.i_supply_ok(i_supply_ok), .i_reset_line(reset_line),
		.i_watchdog_kick_strobe_n(strobe_n),
		.o_reset_line_oe(o_reset_line_oe), .o_reset_line(o_reset_line),
		.o_power_fail(o_power_fail), .o_reset_req(o_reset_req));
	host_button_model #(.KICK_PERIOD(20)) host (
		.i_clk_sys(i_clk_sys), .i_reset_line_oe(o_reset_line_oe),
		.i_press(press), .i_kick_en(kick_en),
		.o_reset_line(reset_line), .o_watchdog_kick_strobe_n(strobe_n));
	// ------------------------------------------------------------
	// Clock, helpers
	// ------------------------------------------------------------
	initial begin
		forever #5 i_clk_sys = ~i_clk_sys;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	// Counts reset cycles, reset starts and watchdog pulses over n cycles
	task automatic watch(input int n);
		logic prev;
		rises = 0;
		highs = 0;
		wd_seen = 0;
		prev = o_reset_line_oe;
		repeat (n) begin
			@(negedge i_clk_sys);
			if (o_reset_line_oe === 1'b1) highs++;
			if (o_reset_line_oe === 1'b1 && prev !== 1'b1) rises++;
			if (o_reset_req.watchdog === 1'b1) wd_seen++;
			prev = o_reset_line_oe;
		end
	endtask : watch
	// Bounce bursts are two cycles low, too short to pass the filter
	task automatic push(input int len, input int bounce);
		repeat (bounce) begin
			press = 1'b1;
			repeat (2) @(negedge i_clk_sys);
			press = 1'b0;
			repeat (2) @(negedge i_clk_sys);
		end
		press = 1'b1;
		repeat (len) @(negedge i_clk_sys);
		press = 1'b0;
	endtask : push
	task automatic summarize();
		if (mismatches == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(negedge i_clk_sys);
		i_reset = 1'b0;
		repeat (4) @(negedge i_clk_sys);
		check(o_reset_line_oe, 1);
		check(o_reset_line, 0);
		check(o_power_fail, 1);
		i_supply_ok = 1'b1;
		watch(HOLD + 20);
		check(highs >= HOLD && highs <= HOLD + 8, 1);
		// Press rows: short, clean and bouncing presses
		foreach (rows[i]) begin
			fork
				push(rows[i].len, rows[i].bounce);
				watch(rows[i].len + 4 * rows[i].bounce + HOLD + 30);
			join
			check(rises, rows[i].pulse);
			check(highs >= HOLD, rows[i].pulse);
		end
		// Supply dip mid-run, then recovery stretch
		i_supply_ok = 1'b0;
		repeat (6) @(negedge i_clk_sys);
		check(o_power_fail, 1);
		check(o_reset_req.power, 1);
		i_supply_ok = 1'b1;
		watch(HOLD + 20);
		check(highs >= HOLD && highs <= HOLD + 8, 1);
		// Regular kicks keep reset away; missing kicks force it
		watch(200);
		check(rises, 0);
		kick_en = 1'b0;
		watch(WDOG + HOLD + 30);
		check(rises, 1);
		check(wd_seen, 1);
		check(highs >= HOLD, 1);
		summarize();
	end
	// Hang guard, far beyond the roughly 740 cycles the tests need
	initial begin
		#50000;
		mismatches++;
		summarize();
	end
endmodule : tb_cpu_supervisor_reset_watchdog
`default_nettype wire
